// >>> hw/ast_defines.svh
// register indices, field positions, reset values and counts
`ifndef AST_DEFINES_SVH
`define AST_DEFINES_SVH

// register indices; byte address is four times the index
`define AST_IDX_INT_FLAG 10'h00c
`define AST_IDX_RX_STATUS 10'h018
`define AST_IDX_TX_BUFFER 10'h019
`define AST_IDX_INT_ENABLE 10'h08c
`define AST_IDX_TX_CONTROL 10'h098
`define AST_IDX_BAUD_DIVISOR 10'h099

// transmit control register fields
`define AST_BIT_CLK_SOURCE 7
`define AST_BIT_NINE_SEL 6
`define AST_BIT_TX_ENABLE 5
`define AST_BIT_CLOCKED 4
`define AST_BIT_HIGH_SPEED 2
`define AST_BIT_SHIFTER_EMPTY 1
`define AST_BIT_NINTH 0
// serial port on, in the receive status register
`define AST_BIT_PORT_ON 7
// buffer empty flag and its enable
`define AST_BIT_BUF_FLAG 4
`define AST_BIT_BUF_IRQ_EN 4

// reset values
`define AST_RST_DIVISOR 8'h00
`define AST_RST_BUFFER 8'h00

// oversampling: last prescaler count, and log2 of the ratio
`define AST_OVS_LAST_HIGH 6'h0f
`define AST_OVS_LAST_LOW 6'h3f
`define AST_OVS_LOG_HIGH 4
`define AST_OVS_LOG_LOW 6

// frame lengths in bits, start and stop included
`define AST_LEN_NINE 4'hb
`define AST_LEN_EIGHT 4'ha

`endif

// >>> hw/ast_pkg.sv
// types shared by the serial transmitter modules
`default_nettype none
package ast_pkg;
  // transmit shifter states
  typedef enum logic [0:0] {AST_IDLE, AST_SEND} ast_tx_state_e;
  // register index type
  typedef logic [9:0] ast_idx_t;
endpackage : ast_pkg
`default_nettype wire

// >>> hw/ast_baud_if.sv
// link between the transmitter core and its baud generator
`default_nettype none
interface ast_baud_if;
  logic run; // generator may count
  logic high_speed; // x16 when set, x64 when clear
  logic clear; // restart timer and prescaler
  logic [7:0] divisor; // timer end count
  logic bit_tick; // one pulse per bit period
  modport gen (input run, input high_speed, input clear, input divisor, output bit_tick);
  modport user (output run, output high_speed, output clear, output divisor, input bit_tick);
endinterface : ast_baud_if
`default_nettype wire

// >>> hw/ast_baud_gen.sv
// baud generator: 8-bit timer and x16/x64 prescaler
`include "ast_defines.svh"
`default_nettype none
module ast_baud_gen
(
  input wire logic i_clk, // system clock
  input wire logic i_rst, // async reset, active high
  ast_baud_if.gen bi // control and tick
);
  import ast_pkg::*;
  logic [7:0] timer; // free running divider
  logic [5:0] pre; // oversampling prescaler
  logic [5:0] pre_last; // end count of prescaler
  logic ovf; // timer reached divisor
  logic tick_now; // bit period ends this cycle
  logic [14:0] per; // run cycles since last tick
  logic seen; // a full period was measured
  logic [14:0] period; // expected period

  // bit period is (divisor + 1) times 16 or 64 clocks
  assign pre_last = bi.high_speed ? `AST_OVS_LAST_HIGH : `AST_OVS_LAST_LOW;
  assign ovf = (timer == bi.divisor);
  assign tick_now = bi.run && ovf && (pre == pre_last) && !bi.clear;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      timer <= 8'h00;
    else if (bi.clear)
      timer <= 8'h00;
    else if (bi.run)
      timer <= ovf ? 8'h00 : timer + 8'h01;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      pre <= 6'h00;
    else if (bi.clear)
      pre <= 6'h00;
    else if (bi.run && ovf)
      pre <= (pre == pre_last) ? 6'h00 : pre + 6'h01;
  end

  // tick registered so the consumer sees a clean pulse
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      bi.bit_tick <= 1'b0;
    else
      bi.bit_tick <= tick_now;
  end

  // helper: measure the period between ticks
  assign period = (15'(bi.divisor) + 15'h0001)
    << (bi.high_speed ? `AST_OVS_LOG_HIGH : `AST_OVS_LOG_LOW);
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      per <= 15'h0000;
      seen <= 1'b0;
    end
    else if (bi.clear || !bi.run)
    begin
      per <= 15'h0000;
      seen <= 1'b0;
    end
    else
    begin
      per <= tick_now ? 15'h0001 : per + 15'h0001;
      seen <= seen | tick_now;
    end
  end

  chk_bit_period_len: assert property (@(posedge i_clk) disable iff (i_rst)
    tick_now && seen |-> per == period) else $error("bit period wrong");
  chk_divisor_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    bi.clear |=> timer == 8'h00 && pre == 6'h00) else $error("timer not cleared");
endmodule : ast_baud_gen
`default_nettype wire

// >>> hw/ast_tx_top.sv
// asynchronous serial transmitter with ahb-lite register slave
`include "ast_defines.svh"
`default_nettype none
// Function
// - nrz frame: start, 8/9 data, stop
// - data bits leave lsb first
// - tx and rx share format, rate
// - 8-bit divider, x16 or x64 clock
// - no hardware parity, ninth bit software
// - sleep halts asynchronous operation
// - clocked-mode bit clear selects async
// - shifter reloads only after stop bit
// - flag cleared only by buffer write
// - irq enable gates the flag
// - shifter empty status is polled
// - setting transmit enable sets flag
// - frame needs data and shift clock
// - write data, then enable, also starts
// - empty shifter takes buffer at once
// - disable aborts, pin goes high-z
// - baud = clock/(16 or 64 * (x+1))
// - divisor write clears baud timer
module ast_tx_top
(
  input wire logic I_MCLK, // system clock, 200 mhz
  input wire logic I_RST, // async reset, active high
  input wire logic I_SLEEP, // device asleep, same clock
  input wire logic I_HSEL, // slave select
  input wire logic [31:0] I_HADDR, // byte address
  input wire logic [1:0] I_HTRANS, // transfer type
  input wire logic I_HWRITE, // write when high
  input wire logic [2:0] I_HSIZE, // word only
  input wire logic [31:0] I_HWDATA, // write data
  input wire logic I_HREADY, // bus ready in
  output logic O_HREADYOUT, // always ready
  output logic [31:0] O_HRDATA, // read data
  output logic O_HRESP, // always okay
  output logic O_TX, // transmit pin level
  output logic O_TX_OE_N, // transmit pin enable, low drives
  output logic O_IRQ // buffer empty request
);
  import ast_pkg::*;
  // ---- register state
  logic [7:0] buf_data; // transmit buffer contents
  logic buf_full; // buffer holds unsent word
  logic clk_src; // stored, unused in async mode
  logic nine_sel; // nine bit frames
  logic tx_en; // transmit enable
  logic clocked; // clocked mode select
  logic hs_sel; // high speed rate select
  logic ninth_val; // ninth bit value
  logic port_on; // serial port on
  logic irq_en; // buffer empty irq enable
  logic flag; // buffer empty flag
  logic [7:0] divisor; // baud divisor
  // ---- bus slave state
  logic ap; // valid address phase
  logic dp_wr; // write data phase pending
  ast_idx_t dp_idx; // index of that write
  logic [7:0] wdat; // low byte of write data
  logic [7:0] rd_val; // read mux result
  ast_idx_t ap_idx; // index in address phase
  logic ap_hit; // address inside decoded window
  // ---- transmitter state
  ast_tx_state_e state; // shifter state
  logic [10:0] sh; // bits still to send
  logic [3:0] cnt; // bits left in frame
  logic async_on; // port on in async mode
  logic tx_act; // transmitter active
  logic run; // active and awake
  logic shift_now; // a bit boundary while sending
  logic load; // buffer moves to shifter
  logic transmit_enable_set; // software turns enable on
  logic wr_buf; // buffer write this cycle
  logic wr_ctrl; // control write this cycle
  logic wr_div; // divisor write this cycle
  // helpers read only by checks
  logic [8:0] last_word; // last word loaded
  logic [3:0] last_len; // length of last frame
  ast_baud_if bi ();
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RST);
  // ---- address phase decode
  assign ap = I_HSEL && I_HTRANS[1] && I_HREADY;
  assign ap_idx = I_HADDR[11:2];
  assign ap_hit = (I_HADDR[31:12] == 20'h00000);
  // bus slave: write latched for its data phase, zero wait states, never an error;
  // ready and response stay flops so every bus output leaves a register
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      dp_wr <= 1'b0;
      dp_idx <= '0;
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end
    else
    begin
      dp_wr <= ap && I_HWRITE && ap_hit;
      dp_idx <= ap_idx;
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end
  end
  assign wdat = I_HWDATA[7:0];
  assign wr_buf = dp_wr && (dp_idx == `AST_IDX_TX_BUFFER);
  assign wr_ctrl = dp_wr && (dp_idx == `AST_IDX_TX_CONTROL);
  assign wr_div = dp_wr && (dp_idx == `AST_IDX_BAUD_DIVISOR);

  // read mux; unmapped and reserved bits read zero
  always_comb
  begin
    rd_val = 8'h00;
    if (ap_hit)
    begin
      unique case (ap_idx)
        `AST_IDX_TX_CONTROL:
          rd_val = {clk_src, nine_sel, tx_en, clocked, 1'b0, hs_sel, state == AST_IDLE, ninth_val};
        `AST_IDX_RX_STATUS: rd_val[`AST_BIT_PORT_ON] = port_on;
        `AST_IDX_TX_BUFFER: rd_val = buf_data;
        `AST_IDX_INT_FLAG: rd_val[`AST_BIT_BUF_FLAG] = flag;
        `AST_IDX_INT_ENABLE: rd_val[`AST_BIT_BUF_IRQ_EN] = irq_en;
        `AST_IDX_BAUD_DIVISOR: rd_val = divisor;
        default: rd_val = 8'h00;
      endcase
    end
  end

  // read data sampled in address phase, stands in data phase;
  // the master idles in the data phase, so no write can intervene
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
      O_HRDATA <= 32'h00000000;
    else if (ap && !I_HWRITE)
      O_HRDATA <= {24'h000000, rd_val};
  end

  // ---- control fields
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      clk_src <= 1'b0;
      nine_sel <= 1'b0;
      tx_en <= 1'b0;
      clocked <= 1'b0;
      hs_sel <= 1'b0;
      ninth_val <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      // shifter empty status is read only, not stored
      clk_src <= wdat[`AST_BIT_CLK_SOURCE];
      nine_sel <= wdat[`AST_BIT_NINE_SEL];
      tx_en <= wdat[`AST_BIT_TX_ENABLE];
      clocked <= wdat[`AST_BIT_CLOCKED];
      hs_sel <= wdat[`AST_BIT_HIGH_SPEED];
      ninth_val <= wdat[`AST_BIT_NINTH];
    end
  end

  // port on, irq enable and divisor each in their own word
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      port_on <= 1'b0;
      irq_en <= 1'b0;
      divisor <= `AST_RST_DIVISOR;
    end
    else
    begin
      if (dp_wr && dp_idx == `AST_IDX_RX_STATUS)
        port_on <= wdat[`AST_BIT_PORT_ON];
      if (dp_wr && dp_idx == `AST_IDX_INT_ENABLE)
        irq_en <= wdat[`AST_BIT_BUF_IRQ_EN];
      if (wr_div)
        divisor <= wdat;
    end
  end

  // enable turning on, seen at the write itself
  assign transmit_enable_set = wr_ctrl && wdat[`AST_BIT_TX_ENABLE] && !tx_en;
  assign async_on = port_on && !clocked;
  assign tx_act = async_on && tx_en;
  assign run = tx_act && !I_SLEEP;
  // ---- baud generator, shared with a receiver
  // one rate for both
  assign bi.run = async_on && !I_SLEEP;
  assign bi.high_speed = hs_sel;
  assign bi.clear = wr_div;
  assign bi.divisor = divisor;

  ast_baud_gen u_baud (
    .i_clk (I_MCLK),
    .i_rst (I_RST),
    .bi (bi)
  );
  assign shift_now = run && bi.bit_tick && (state == AST_SEND);
  assign load = run && (state == AST_IDLE) && buf_full;
  // ---- transmit buffer
  // buffer kept while disabled
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      buf_data <= `AST_RST_BUFFER;
      buf_full <= 1'b0;
    end
    else
    begin
      if (wr_buf)
        buf_data <= wdat;
      // a write in the load cycle refills it: set wins
      if (wr_buf)
        buf_full <= 1'b1;
      else if (load)
        buf_full <= 1'b0;
    end
  end

  // ---- buffer empty flag
  // set wins over clear
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
      flag <= 1'b0;
    else if (load || transmit_enable_set)
      flag <= 1'b1;
    // only a buffer write clears; flag register writes ignored
    else if (wr_buf)
      flag <= 1'b0;
  end

  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
      O_IRQ <= 1'b0;
    else
      O_IRQ <= flag && irq_en;
  end

  // ---- transmit shifter
  // the frame starts on the next bit tick after the load, so the
  // start bit is a whole period long; up to one period of latency
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      state <= AST_IDLE;
      sh <= 11'h7ff;
      cnt <= 4'h0;
    end
    else if (!tx_act)
    begin
      state <= AST_IDLE;
      sh <= 11'h7ff;
      cnt <= 4'h0;
    end
    else if (run)
    begin
      unique case (state)
        AST_IDLE:
        begin
          if (buf_full)
          begin
            state <= AST_SEND;
            // ninth bit as written; an eight bit frame pads with mark
            sh <= {1'b1, nine_sel ? ninth_val : 1'b1, buf_data, 1'b0};
            cnt <= nine_sel ? `AST_LEN_NINE : `AST_LEN_EIGHT;
          end
        end
        AST_SEND:
        begin
          if (bi.bit_tick)
          begin
            if (cnt == 4'h0)
              state <= AST_IDLE;
            else
            begin
              sh <= {1'b1, sh[10:1]};
              cnt <= cnt - 4'h1;
            end
          end
        end
      endcase
    end
  end

  // ---- pin
  // mark high when idle
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
      O_TX <= 1'b1;
    else if (!tx_act)
      O_TX <= 1'b1;
    else if (shift_now)
      O_TX <= (cnt == 4'h0) ? 1'b1 : sh[0];
  end

  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
      O_TX_OE_N <= 1'b1;
    else
      O_TX_OE_N <= !tx_act;
  end

  // helper: remember the loaded word for the checks
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      last_word <= 9'h000;
      last_len <= 4'h0;
    end
    else if (load)
    begin
      last_word <= {ninth_val, buf_data};
      last_len <= nine_sel ? `AST_LEN_NINE : `AST_LEN_EIGHT;
    end
  end

  // ---- checks
  chk_start_bit_low: assert property (
    shift_now && cnt == last_len |=> !O_TX && !O_TX_OE_N) else $error("start bit not low");
  chk_data_lsb_first: assert property (shift_now && cnt == last_len - 4'h1
    |=> O_TX == last_word[0]) else $error("first data bit is not the lsb");
  chk_stop_bit_high: assert property (
    shift_now && cnt == 4'h1 |=> O_TX ##1 O_TX) else $error("stop bit not high");
  // a buffer write in the load cycle legally leaves the buffer full
  chk_flag_on_load: assert property (
    load |=> flag && buf_full == $past(wr_buf) && state == AST_SEND) else $error("load missed");
  chk_flag_write_clear: assert property (
    wr_buf && !load && !transmit_enable_set |=> !flag) else $error("buffer write left flag set");
  chk_irq_gate_flag: assert property (
    !irq_en |=> !O_IRQ) else $error("irq raised while disabled");
  chk_enable_sets_flag: assert property (
    transmit_enable_set |=> flag) else $error("enable did not set flag");
  chk_abort_releases_pin: assert property (
    $fell(tx_en) |=> O_TX_OE_N && state == AST_IDLE) else $error("disable did not abort");
  chk_sleep_halts_shift: assert property (
    I_SLEEP && tx_act |=> $stable(cnt) && $stable(O_TX)) else $error("shifter moved in sleep");
  chk_nine_bit_length: assert property (
    load && nine_sel |=> cnt == 4'hb) else $error("nine bit frame length wrong");
  chk_no_early_reload: assert property (state == AST_SEND && cnt != 4'h0
    |=> state == AST_SEND || !tx_act) else $error("shifter freed before stop bit");
endmodule : ast_tx_top
`default_nettype wire

// >>> verification/ast_rx_model.sv
// remote receiver model sampling the transmit line mid-bit
`default_nettype none
module ast_rx_model
(
  input wire logic i_clk, // system clock
  input wire logic i_line, // transmit pin level
  input wire logic i_oe_n, // pin enable, low drives
  input wire logic [15:0] i_bit_clks, // clocks per bit
  input wire logic i_nine, // nine data bits expected
  output logic [8:0] o_data, // last good word
  output int o_frames // good frames seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic line; // pulled up when released
  logic ok; // frame still valid
  logic [8:0] sh; // bits gathered
  int n; // data bits this frame
  assign line = i_oe_n ? 1'b1 : i_line;
  // frames are timed from the start edge, so a wrong rate shows as bad data
  initial
  begin
    o_data = 9'h000;
    o_frames = 0;
    forever
    begin
      @(posedge i_clk);
      if (line === 1'b0)
      begin
        sh = 9'h000;
        n = i_nine ? 9 : 8;
        repeat (i_bit_clks / 2) @(posedge i_clk);
        ok = (line === 1'b0);
        for (int k = 0; k < n; k++)
        begin
          repeat (i_bit_clks) @(posedge i_clk);
          sh[k] = line;
          ok = ok & ~i_oe_n;
        end
        repeat (i_bit_clks) @(posedge i_clk);
        ok = ok & (line === 1'b1) & ~i_oe_n;
        // released pin mid frame discards it
        if (ok)
        begin
          o_data = sh;
          o_frames++;
        end
      end
    end
  end
endmodule : ast_rx_model
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the serial transmitter
`include "ast_defines.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] dv; logic hs; logic nine; logic b9; logic [7:0] d;} ast_row_s;
  localparam logic [31:0] A_FLG = {20'h0, `AST_IDX_INT_FLAG, 2'b00};
  localparam logic [31:0] A_RXS = {20'h0, `AST_IDX_RX_STATUS, 2'b00};
  localparam logic [31:0] A_BUF = {20'h0, `AST_IDX_TX_BUFFER, 2'b00};
  localparam logic [31:0] A_IEN = {20'h0, `AST_IDX_INT_ENABLE, 2'b00};
  localparam logic [31:0] A_CTL = {20'h0, `AST_IDX_TX_CONTROL, 2'b00};
  localparam logic [31:0] A_DIV = {20'h0, `AST_IDX_BAUD_DIVISOR, 2'b00};
  logic clk, rst, sleep, hsel, hwrite, hrdy, hresp, tx, oe_n, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] bclk; // clocks per bit for the model
  logic nine; // model expects nine bits
  logic [8:0] rx_data;
  int rx_frames, error_cnt, num_checks, cyc, f;
  // rows: divisor, rate, format, ninth bit, data
  ast_row_s rows [4] = '{'{8'h00, 1'b1, 1'b0, 1'b0, 8'ha5}, '{8'h02, 1'b1, 1'b1, 1'b1, 8'h3c},
                         '{8'h00, 1'b0, 1'b1, 1'b0, 8'h81}, '{8'h01, 1'b0, 1'b0, 1'b1, 8'h7e}};
  ast_tx_top ast_tx_top_i (.I_MCLK(clk), .I_RST(rst), .I_SLEEP(sleep), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
    .I_HREADY(hrdy), .O_HREADYOUT(hrdy), .O_HRDATA(hrdata), .O_HRESP(hresp), .O_TX(tx),
    .O_TX_OE_N(oe_n), .O_IRQ(irq));
  ast_rx_model ast_rx_model_i (.i_clk(clk), .i_line(tx), .i_oe_n(oe_n), .i_bit_clks(bclk),
    .i_nine(nine), .o_data(rx_data), .o_frames(rx_frames));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // hang guard, well above the longest run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one single ahb transfer, waiting on ready in both phases
  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hrdy !== 1'b1);
    q = hrdata;
    chk(hresp, 1'b0);
  endtask : xfer
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask : rc
  // bounded wait for the next good frame, then its word
  task automatic frame(input logic [8:0] exp);
    int c;
    c = 0;
    while (rx_frames == f && c < 8000)
    begin
      @(posedge clk);
      c++;
    end
    chk(rx_frames, f + 1);
    chk({23'h0, rx_data}, {23'h0, exp});
    f = rx_frames;
  endtask : frame
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  initial
  begin
    {rst, sleep, hsel, hwrite, htrans, haddr, hwdata, nine, cyc, error_cnt, num_checks} = '0;
    rst = 1'b1;
    hsize = 3'h2;
    bclk = 16'h0010;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    f = 0;
    wr(A_RXS, 8'h80);
    // rate and format sweep, each word checked at the remote end
    foreach (rows[i])
    begin
      bclk <= 16'((rows[i].dv + 1) * (rows[i].hs ? 16 : 64));
      nine <= rows[i].nine;
      wr(A_DIV, rows[i].dv);
      wr(A_CTL, {1'b0, rows[i].nine, 3'b100, rows[i].hs, 1'b0, rows[i].b9});
      wr(A_BUF, rows[i].d);
      frame({rows[i].nine & rows[i].b9, rows[i].d});
      repeat (bclk) @(posedge clk);
      rc(A_CTL, {25'h0, rows[i].nine, 3'b100, rows[i].hs, 1'b1, rows[i].b9});
      $display("row %0d done", i);
    end
    bclk <= 16'h0010;
    nine <= 1'b0;
    wr(A_DIV, 8'h00);
    wr(A_CTL, 8'h04);
    wr(A_CTL, 8'h24);
    rc(A_FLG, 32'h10);
    wr(A_FLG, 8'h00);
    rc(A_FLG, 32'h10);
    wr(A_IEN, 8'h10);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    wr(A_IEN, 8'h00);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    $display("flag test done");
    wr(A_BUF, 8'h11);
    rc(A_FLG, 32'h10);
    wr(A_BUF, 8'h22);
    rc(A_FLG, 32'h00);
    rc(A_CTL, 32'h24);
    frame(9'h011);
    frame(9'h022);
    $display("back to back done");
    wr(A_BUF, 8'h55);
    repeat (80) @(posedge clk);
    chk(oe_n, 1'b0);
    wr(A_CTL, 8'h04);
    repeat (2) @(posedge clk);
    chk({oe_n, tx}, 2'b11);
    rc(A_CTL, 32'h06);
    wr(A_BUF, 8'h69);
    repeat (320) @(posedge clk);
    chk(rx_frames, f);
    wr(A_CTL, 8'h24);
    frame(9'h069);
    $display("abort test done");
    sleep <= 1'b1;
    wr(A_BUF, 8'h0f);
    repeat (300) @(posedge clk);
    chk({rx_frames[0], tx}, {f[0], 1'b1});
    sleep <= 1'b0;
    frame(9'h00f);
    wr(A_CTL, 8'h34);
    repeat (2) @(posedge clk);
    chk(oe_n, 1'b1);
    wr(A_BUF, 8'h33);
    repeat (300) @(posedge clk);
    chk(rx_frames, f);
    wr(A_CTL, 8'h24);
    frame(9'h033);
    $display("mode test done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk({hrdy, hresp, tx, oe_n, irq}, 5'h16);
    rst <= 1'b0;
    rc(A_CTL, 32'h02);
    rc(A_DIV, 32'h00);
    rc(A_FLG, 32'h00);
    // buffer empty after reset, so only the enable can raise the flag
    wr(A_RXS, 8'h80);
    wr(A_CTL, 8'h20);
    rc(A_FLG, 32'h10);
    wr(32'h0000_0004, 8'hff);
    rc(32'h0000_0004, 32'h00);
    $display("reset test done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
